// *** rtl/clk_seq_pkg.sv ***
// Shared constants and types for the CPU clock state sequencer
`default_nettype none
package clk_seq_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_OSC_MODE = 8'h00;
  localparam logic [7:0] OFF_MAIN_OSC = 8'h04;
  localparam logic [7:0] OFF_MAIN_MODE = 8'h08;
  localparam logic [7:0] OFF_INT_OSC = 8'h0C;
  localparam logic [7:0] OFF_PROC_CLK = 8'h10;
  localparam logic [7:0] OFF_STAB_CNT = 8'h14;
  // ==========================================
  // Field positions
  localparam int unsigned BIT_EXT_SEL = 7;
  localparam int unsigned BIT_X1_EN = 6;
  localparam int unsigned BIT_XT1_EN = 4;
  localparam int unsigned BIT_GAIN = 0;
  localparam int unsigned BIT_MAIN_HALT = 7;
  localparam int unsigned BIT_HS_SEL = 2;
  localparam int unsigned BIT_MAIN_STAT = 1;
  localparam int unsigned BIT_MUX = 0;
  localparam int unsigned BIT_RUN_FLAG = 7;
  localparam int unsigned BIT_INT_HALT = 0;
  localparam int unsigned BIT_CPU_STAT = 5;
  localparam int unsigned BIT_SUB_SEL = 4;
  localparam int unsigned DIV_MSB = 2;
  // ==========================================
  // Reset values
  localparam logic [7:0] RST_OSC_MODE = 8'h00;
  localparam logic [7:0] RST_MAIN_OSC = 8'h80;
  localparam logic [7:0] RST_MAIN_MODE = 8'h00;
  localparam logic [7:0] RST_INT_OSC = 8'h00;
  localparam logic [7:0] RST_PROC_CLK = 8'h01;
  // ==========================================
  // Timing
  localparam int unsigned CLK_FREQ_MHZ = 50;
  localparam int unsigned RESET_PROC_US = 45;
  localparam int unsigned RESET_PROC_CYC = RESET_PROC_US * CLK_FREQ_MHZ;
  localparam int unsigned RST_CNT_W = 12;
  localparam logic [RST_CNT_W-1:0] RESET_LAST = RST_CNT_W'(RESET_PROC_CYC - 1);
  // ==========================================
  // Types
  typedef enum logic [1:0] {SRC_INT, SRC_HIGH, SRC_SUB} src_t;
  typedef enum logic [3:0] {
    CS_OFF, CS_RESET, CS_INT_RUN, CS_HIGH_RUN, CS_SUB_RUN,
    CS_INT_HALT, CS_HIGH_HALT, CS_SUB_HALT
  } clk_state_t;
  typedef struct packed {
    logic int_hs;
    logic int_ls;
    logic x1;
    logic ext;
    logic xt1;
  } osc_en_t;
endpackage
`default_nettype wire

// *** rtl/clk_glitch_free_switch.sv ***
// Glitch-free handover of the CPU clock between sources
`default_nettype none
module clk_glitch_free_switch (
  input wire logic pclk,
  input wire logic presetn,
  input var clk_seq_pkg::src_t target,
  input wire logic [2:0] src_safe_edge,
  output clk_seq_pkg::src_t cur_src,
  output logic gate,
  output logic busy
);
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_OLD, SW_WAIT_NEW} sw_state_t;

  function automatic logic edge_of(input logic [2:0] e, input clk_seq_pkg::src_t s);
    case (s)
      clk_seq_pkg::SRC_INT: edge_of = e[0];
      clk_seq_pkg::SRC_HIGH: edge_of = e[1];
      clk_seq_pkg::SRC_SUB: edge_of = e[2];
      default: edge_of = 1'b0;
    endcase
  endfunction

  sw_state_t st_q, st_d;
  clk_seq_pkg::src_t cur_q, cur_d, next_q, next_d;
  logic gate_q, gate_d;
  wire logic old_edge = edge_of(src_safe_edge, cur_q);
  wire logic new_edge = edge_of(src_safe_edge, next_q);

  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    next_d = next_q;
    gate_d = gate_q;
    unique case (st_q)
      SW_IDLE: if (target != cur_q) begin
        next_d = target;
        gate_d = 1'b0;
        st_d = SW_WAIT_OLD;
      end
      SW_WAIT_OLD: if (old_edge) begin
        st_d = SW_WAIT_NEW;
      end
      SW_WAIT_NEW: if (new_edge) begin
        cur_d = next_q;
        gate_d = 1'b1;
        st_d = SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SW_IDLE;
      cur_q <= clk_seq_pkg::SRC_INT;
      next_q <= clk_seq_pkg::SRC_INT;
      gate_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      next_q <= next_d;
      gate_q <= gate_d;
    end
  end

  assign cur_src = cur_q;
  assign gate = gate_q;
  assign busy = (st_q != SW_IDLE);

  switch_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cur_q != $past(cur_q)) |-> $past(new_edge) && $past(st_q) == SW_WAIT_NEW)
    else $error("Source changed without safe edge");
  switch_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q != SW_IDLE) |-> !gate_q)
    else $error("CPU clock gated on during handover");
endmodule
`default_nettype wire

// *** rtl/cpu_clock_state_sequencer.sv ***
// CPU clock state sequencer with APB control registers
//
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none
module cpu_clock_state_sequencer #(
  parameter bit HAS_SUB = 1'b1,
  parameter int unsigned STAB_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_clear_threshold_option,
  input wire logic supply_above_low,
  input wire logic supply_above_high,
  input wire logic halt_exec,
  input wire logic halt_release,
  input wire logic int_osc_stable,
  input wire logic x1_tick,
  input wire logic [2:0] src_safe_edge,
  output clk_seq_pkg::osc_en_t osc_en,
  output clk_seq_pkg::src_t cpu_src,
  output logic cpu_clk_en,
  output clk_seq_pkg::clk_state_t clk_state
);
  typedef enum logic [1:0] {SEQ_POC, SEQ_RESET, SEQ_RUN, SEQ_HALT} seq_t;

  // ==========================================
  // APB decode
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable;
  wire logic wr = access & pwrite;
  wire logic sel_osc = (paddr == clk_seq_pkg::OFF_OSC_MODE);
  wire logic sel_moc = (paddr == clk_seq_pkg::OFF_MAIN_OSC);
  wire logic sel_mcm = (paddr == clk_seq_pkg::OFF_MAIN_MODE);
  wire logic sel_int = (paddr == clk_seq_pkg::OFF_INT_OSC);
  wire logic sel_pcc = (paddr == clk_seq_pkg::OFF_PROC_CLK);
  wire logic sel_stab = (paddr == clk_seq_pkg::OFF_STAB_CNT);
  wire logic mapped = sel_osc | sel_moc | sel_mcm | sel_int | sel_pcc | sel_stab;
  wire logic [7:0] wbyte = pwdata[7:0];

  // ==========================================
  // Control bits
  logic ext_sel_q, x1_en_q, xt1_en_q, gain_q, gain_used_q;
  logic main_halt_q, hs_sel_q, hs_used_q, mux_q, int_halt_q, sub_sel_q;
  logic [clk_seq_pkg::DIV_MSB:0] div_q;
  seq_t seq_q, seq_d;
  logic [clk_seq_pkg::RST_CNT_W-1:0] rst_cnt_q;
  logic [STAB_W-1:0] stab_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  wire logic gain_take = wr & sel_osc & ~gain_used_q & (wbyte[clk_seq_pkg::BIT_GAIN] != gain_q);
  wire logic hs_take = wr & sel_mcm & ~hs_used_q & (wbyte[clk_seq_pkg::BIT_HS_SEL] != hs_sel_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_q <= clk_seq_pkg::RST_OSC_MODE[clk_seq_pkg::BIT_EXT_SEL];
      x1_en_q <= clk_seq_pkg::RST_OSC_MODE[clk_seq_pkg::BIT_X1_EN];
      xt1_en_q <= clk_seq_pkg::RST_OSC_MODE[clk_seq_pkg::BIT_XT1_EN];
    end else if (wr && sel_osc) begin
      ext_sel_q <= wbyte[clk_seq_pkg::BIT_EXT_SEL];
      x1_en_q <= wbyte[clk_seq_pkg::BIT_X1_EN];
      // no subsystem oscillator in small build
      xt1_en_q <= wbyte[clk_seq_pkg::BIT_XT1_EN] & HAS_SUB;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_q <= clk_seq_pkg::RST_OSC_MODE[clk_seq_pkg::BIT_GAIN];
      gain_used_q <= 1'b0;
      hs_sel_q <= clk_seq_pkg::RST_MAIN_MODE[clk_seq_pkg::BIT_HS_SEL];
      hs_used_q <= 1'b0;
    end else begin
      if (gain_take) begin
        gain_q <= wbyte[clk_seq_pkg::BIT_GAIN];
        gain_used_q <= 1'b1;
      end
      if (hs_take) begin
        hs_sel_q <= wbyte[clk_seq_pkg::BIT_HS_SEL];
        hs_used_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_halt_q <= clk_seq_pkg::RST_MAIN_OSC[clk_seq_pkg::BIT_MAIN_HALT];
      mux_q <= clk_seq_pkg::RST_MAIN_MODE[clk_seq_pkg::BIT_MUX];
      int_halt_q <= clk_seq_pkg::RST_INT_OSC[clk_seq_pkg::BIT_INT_HALT];
      sub_sel_q <= clk_seq_pkg::RST_PROC_CLK[clk_seq_pkg::BIT_SUB_SEL];
      div_q <= clk_seq_pkg::RST_PROC_CLK[clk_seq_pkg::DIV_MSB:0];
    end else if (wr) begin
      if (sel_moc) main_halt_q <= wbyte[clk_seq_pkg::BIT_MAIN_HALT];
      if (sel_mcm) mux_q <= wbyte[clk_seq_pkg::BIT_MUX];
      if (sel_int) int_halt_q <= wbyte[clk_seq_pkg::BIT_INT_HALT];
      if (sel_pcc) begin
        sub_sel_q <= wbyte[clk_seq_pkg::BIT_SUB_SEL] & HAS_SUB;
        div_q <= wbyte[clk_seq_pkg::DIV_MSB:0];
      end
    end
  end

  // ==========================================
  // Power-on and reset sequencing
  // Option read live; a registered copy lags the first edge
  wire logic thr_ok = power_on_clear_threshold_option ? supply_above_high : supply_above_low;
  wire logic sw_busy;
  wire logic sw_gate;

  always_comb begin
    seq_d = seq_q;
    unique case (seq_q)
      SEQ_POC: if (thr_ok) seq_d = SEQ_RESET;
      SEQ_RESET: if (rst_cnt_q == clk_seq_pkg::RESET_LAST) seq_d = SEQ_RUN;
      SEQ_RUN: if (halt_exec && !sw_busy) seq_d = SEQ_HALT;
      SEQ_HALT: if (halt_release) seq_d = SEQ_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= SEQ_POC;
      rst_cnt_q <= '0;
    end else begin
      seq_q <= seq_d;
      if (seq_q == SEQ_RESET) rst_cnt_q <= rst_cnt_q + 1'b1;
      else rst_cnt_q <= '0;
    end
  end

  // ==========================================
  // Oscillator enables and source choice
  wire logic in_run = (seq_q == SEQ_RUN) | (seq_q == SEQ_HALT);
  wire logic main_on = in_run & x1_en_q & ~main_halt_q;
  wire logic sub_eff = HAS_SUB & sub_sel_q;
  wire logic main_high = hs_sel_q & mux_q;
  clk_seq_pkg::src_t target_src;
  assign target_src = sub_eff ? clk_seq_pkg::SRC_SUB :
                      main_high ? clk_seq_pkg::SRC_HIGH : clk_seq_pkg::SRC_INT;

  assign osc_en.int_hs = ~(in_run & int_halt_q);
  assign osc_en.int_ls = 1'b1;
  // stop bit gates crystal and external input
  assign osc_en.x1 = main_on & ~ext_sel_q;
  assign osc_en.ext = main_on & ext_sel_q;
  assign osc_en.xt1 = in_run & HAS_SUB & xt1_en_q;

  wire logic run_flag = int_osc_stable & osc_en.int_hs;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_q <= '0;
    end else if (!osc_en.x1) begin
      stab_q <= '0;
    end else if (x1_tick && stab_q != '1) begin
      stab_q <= stab_q + 1'b1;
    end
  end

  clk_glitch_free_switch u_switch (
    .pclk(pclk),
    .presetn(presetn),
    .target(target_src),
    .src_safe_edge(src_safe_edge),
    .cur_src(cpu_src),
    .gate(sw_gate),
    .busy(sw_busy)
  );

  assign cpu_clk_en = sw_gate & (seq_q == SEQ_RUN);

  always_comb begin
    unique case (seq_q)
      SEQ_POC: clk_state = clk_seq_pkg::CS_OFF;
      SEQ_RESET: clk_state = clk_seq_pkg::CS_RESET;
      SEQ_RUN: clk_state = (cpu_src == clk_seq_pkg::SRC_SUB) ? clk_seq_pkg::CS_SUB_RUN :
                           (cpu_src == clk_seq_pkg::SRC_HIGH) ? clk_seq_pkg::CS_HIGH_RUN :
                           clk_seq_pkg::CS_INT_RUN;
      SEQ_HALT: clk_state = (cpu_src == clk_seq_pkg::SRC_SUB) ? clk_seq_pkg::CS_SUB_HALT :
                            (cpu_src == clk_seq_pkg::SRC_HIGH) ? clk_seq_pkg::CS_HIGH_HALT :
                            clk_seq_pkg::CS_INT_HALT;
    endcase
  end

  // ==========================================
  // Read path
  wire logic main_stat = (cpu_src == clk_seq_pkg::SRC_HIGH) |
                         ((cpu_src == clk_seq_pkg::SRC_SUB) & main_high);
  wire logic cpu_stat = (cpu_src == clk_seq_pkg::SRC_SUB);
  wire logic [7:0] rd_osc = {ext_sel_q, x1_en_q, 1'b0, xt1_en_q, 3'b000, gain_q};
  wire logic [7:0] rd_moc = {main_halt_q, 7'h00};
  wire logic [7:0] rd_mcm = {5'h00, hs_sel_q, main_stat, mux_q};
  wire logic [7:0] rd_int = {run_flag, 6'h00, int_halt_q};
  wire logic [7:0] rd_pcc = {2'b00, cpu_stat, sub_eff, 1'b0, div_q};
  wire logic [31:0] rd_stab = 32'(stab_q);
  wire logic [31:0] rd_word = sel_stab ? rd_stab :
                              {24'h00_0000, ({8{sel_osc}} & rd_osc) | ({8{sel_moc}} & rd_moc) |
                               ({8{sel_mcm}} & rd_mcm) | ({8{sel_int}} & rd_int) | ({8{sel_pcc}} & rd_pcc)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_word;
      pslverr_q <= ~mapped;
    end else if (!psel) begin
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q;

  // ==========================================
  // Checks
  sequence reset_done_s;
    seq_q == SEQ_RESET ##1 seq_q == SEQ_RUN;
  endsequence
  sequence halt_enter_s;
    seq_q == SEQ_RUN && halt_exec && !sw_busy;
  endsequence

  rst_proc_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_q == SEQ_RESET && seq_d == SEQ_RUN) |-> rst_cnt_q == clk_seq_pkg::RESET_LAST)
    else $error("Reset processing length wrong");
  reset_ports_a: assert property (@(posedge pclk) disable iff (!presetn)
    !in_run |-> osc_en.int_hs && osc_en.int_ls && !osc_en.x1 && !osc_en.ext && !osc_en.xt1)
    else $error("Pins left port mode during reset");
  default_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    reset_done_s |-> cpu_src == clk_seq_pkg::SRC_INT && cpu_clk_en)
    else $error("Not on internal oscillator after reset");
  gain_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    gain_used_q |=> gain_q == $past(gain_q))
    else $error("Gain bit changed twice");
  hs_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    (hs_used_q ##1 wr && sel_mcm) |=> $stable(hs_sel_q))
    else $error("High-speed select changed twice");
  main_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!hs_sel_q && !sub_eff) |-> target_src == clk_seq_pkg::SRC_INT)
    else $error("Mux honoured with select low");
  halt_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    halt_enter_s |=> seq_q == SEQ_HALT && !cpu_clk_en && cpu_src == $past(cpu_src))
    else $error("Halt entry wrong");
  stab_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (osc_en.ext || main_halt_q) |=> stab_q == '0)
    else $error("Stabilization count without crystal");
  stop_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_halt_q |-> !osc_en.x1 && !osc_en.ext)
    else $error("Main oscillator runs while stopped");
  sub_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sub_eff && cpu_src != clk_seq_pkg::SRC_SUB) |-> ##1 cpu_src != clk_seq_pkg::SRC_SUB)
    else $error("Subsystem clock routed without select");
  no_sub_a: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_SUB |-> !osc_en.xt1 && cpu_src != clk_seq_pkg::SRC_SUB && !sub_sel_q)
    else $error("Subsystem present in small build");
  poc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_q == SEQ_POC && power_on_clear_threshold_option && !supply_above_high) |=> seq_q == SEQ_POC)
    else $error("Left power-on wait below high threshold");
  run_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_run && int_halt_q) |-> !run_flag)
    else $error("Running flag set while oscillator stopped");
  main_osc_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_run && x1_en_q && !main_halt_q) |-> (osc_en.x1 || osc_en.ext))
    else $error("Main oscillator idle while enabled");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the CPU clock state sequencer
`default_nettype none
// Compare two values and count the outcome
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, cpu_clk_en;
  logic thr_opt, sup_low, sup_high, halt_exec, halt_release, int_osc_stable, x1_tick;
  logic [2:0] src_safe_edge;
  clk_seq_pkg::osc_en_t osc_en;
  clk_seq_pkg::src_t cpu_src;
  clk_seq_pkg::clk_state_t clk_state;
  clk_seq_pkg::osc_en_t osc_en_s;
  clk_seq_pkg::src_t cpu_src_s;
  clk_seq_pkg::clk_state_t clk_state_s;
  int fails = 0;
  int samples_checked = 0;

  cpu_clock_state_sequencer #(.HAS_SUB(1'b1), .STAB_W(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_clear_threshold_option(thr_opt), .supply_above_low(sup_low),
    .supply_above_high(sup_high), .halt_exec(halt_exec), .halt_release(halt_release),
    .int_osc_stable(int_osc_stable), .x1_tick(x1_tick), .src_safe_edge(src_safe_edge),
    .osc_en(osc_en), .cpu_src(cpu_src), .cpu_clk_en(cpu_clk_en), .clk_state(clk_state)
  );
  // Small build shares all inputs
  cpu_clock_state_sequencer #(.HAS_SUB(1'b0), .STAB_W(16)) dut_small (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .power_on_clear_threshold_option(thr_opt), .supply_above_low(sup_low),
    .supply_above_high(sup_high), .halt_exec(halt_exec), .halt_release(halt_release),
    .int_osc_stable(int_osc_stable), .x1_tick(x1_tick), .src_safe_edge(src_safe_edge),
    .osc_en(osc_en_s), .cpu_src(cpu_src_s), .cpu_clk_en(), .clk_state(clk_state_s)
  );

  // ==========================================
  // Clock, verdict and watchdog
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic test_done();
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done();
  end

  // ==========================================
  // APB master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h00_0000, d}, rd, err);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(rd, exp)
    `CHK(err, 1'b0)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // ==========================================
  // Scenario tasks
  task automatic pulse_edges(input int old_i, input int new_i);
    @(posedge pclk);
    src_safe_edge <= 3'(1 << old_i);
    @(posedge pclk);
    src_safe_edge <= 3'(1 << new_i);
    @(posedge pclk);
    src_safe_edge <= 3'h0;
  endtask
  task automatic do_switch(input int old_i, input int new_i, input clk_seq_pkg::src_t src,
                           input clk_seq_pkg::clk_state_t st);
    wait_cyc(4);
    `CHK(cpu_clk_en, 1'b0)
    pulse_edges(old_i, new_i);
    #1;
    `CHK(cpu_clk_en, 1'b1)
    `CHK(cpu_src, src)
    `CHK(clk_state, st)
  endtask
  task automatic do_halt(input clk_seq_pkg::clk_state_t hst, input clk_seq_pkg::clk_state_t rst);
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    wait_cyc(2);
    `CHK(clk_state, hst)
    `CHK(cpu_clk_en, 1'b0)
    @(posedge pclk);
    halt_release <= 1'b1;
    @(posedge pclk);
    halt_release <= 1'b0;
    wait_cyc(2);
    `CHK(clk_state, rst)
  endtask
  task automatic poc_and_reset();
    logic [7:0] offs [5] = '{clk_seq_pkg::OFF_OSC_MODE, clk_seq_pkg::OFF_MAIN_OSC,
      clk_seq_pkg::OFF_MAIN_MODE, clk_seq_pkg::OFF_INT_OSC, clk_seq_pkg::OFF_PROC_CLK};
    logic [31:0] exps [5] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0000, 32'h0000_0080, 32'h0000_0001};
    int n = 0;
    #1;
    `CHK(clk_state, clk_seq_pkg::CS_OFF)
    `CHK(osc_en, 5'h18)
    wait_cyc(10);
    `CHK(clk_state, clk_seq_pkg::CS_OFF)
    for (int i = 0; i < 5; i++) chk_rd(offs[i], exps[i]);
    @(posedge pclk);
    sup_high <= 1'b1;
    while (clk_state !== clk_seq_pkg::CS_RESET && n < 5) begin
      wait_cyc(1);
      n++;
    end
    `CHK(osc_en, 5'h18)
    n = 0;
    while (clk_state === clk_seq_pkg::CS_RESET && n < 3000) begin
      wait_cyc(1);
      n++;
    end
    `CHK(n, 32'(clk_seq_pkg::RESET_PROC_CYC))
    `CHK(clk_state, clk_seq_pkg::CS_INT_RUN)
    `CHK(cpu_src, clk_seq_pkg::SRC_INT)
    `CHK(cpu_clk_en, 1'b1)
  endtask
  task automatic once_only_bits();
    logic [31:0] rd;
    logic err;
    wr(clk_seq_pkg::OFF_MAIN_MODE, 8'h01);
    wait_cyc(6);
    `CHK(cpu_src, clk_seq_pkg::SRC_INT)
    `CHK(cpu_clk_en, 1'b1)
    wr(clk_seq_pkg::OFF_MAIN_MODE, 8'h04);
    wr(clk_seq_pkg::OFF_MAIN_MODE, 8'h00);
    chk_rd(clk_seq_pkg::OFF_MAIN_MODE, 32'h0000_0004);
    `CHK(cpu_src, clk_seq_pkg::SRC_INT)
    wr(clk_seq_pkg::OFF_OSC_MODE, 8'h01);
    wr(clk_seq_pkg::OFF_OSC_MODE, 8'h00);
    chk_rd(clk_seq_pkg::OFF_OSC_MODE, 32'h0000_0001);
    apb(1'b1, 8'h3C, 32'h0000_00FF, rd, err);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h3C, 32'h0000_0000, rd, err);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic to_high_speed();
    wr(clk_seq_pkg::OFF_OSC_MODE, 8'h40);
    wr(clk_seq_pkg::OFF_MAIN_OSC, 8'h00);
    wait_cyc(1);
    `CHK(osc_en.x1, 1'b1)
    repeat (5) begin
      @(posedge pclk);
      x1_tick <= 1'b1;
      @(posedge pclk);
      x1_tick <= 1'b0;
    end
    chk_rd(clk_seq_pkg::OFF_STAB_CNT, 32'h0000_0005);
    wr(clk_seq_pkg::OFF_MAIN_MODE, 8'h05);
    do_switch(0, 1, clk_seq_pkg::SRC_HIGH, clk_seq_pkg::CS_HIGH_RUN);
    chk_rd(clk_seq_pkg::OFF_MAIN_MODE, 32'h0000_0007);
  endtask
  task automatic back_to_internal();
    chk_rd(clk_seq_pkg::OFF_INT_OSC, 32'h0000_0080);
    wr(clk_seq_pkg::OFF_MAIN_MODE, 8'h04);
    do_switch(1, 0, clk_seq_pkg::SRC_INT, clk_seq_pkg::CS_INT_RUN);
  endtask
  task automatic sub_round_trip();
    wr(clk_seq_pkg::OFF_OSC_MODE, 8'h51);
    wait_cyc(1);
    `CHK(osc_en.xt1, 1'b1)
    wr(clk_seq_pkg::OFF_PROC_CLK, 8'h11);
    do_switch(0, 2, clk_seq_pkg::SRC_SUB, clk_seq_pkg::CS_SUB_RUN);
    `CHK(osc_en_s.xt1, 1'b0)
    `CHK(cpu_src_s, clk_seq_pkg::SRC_INT)
    `CHK(clk_state_s, clk_seq_pkg::CS_INT_RUN)
    chk_rd(clk_seq_pkg::OFF_PROC_CLK, 32'h0000_0031);
    do_halt(clk_seq_pkg::CS_SUB_HALT, clk_seq_pkg::CS_SUB_RUN);
    wr(clk_seq_pkg::OFF_MAIN_MODE, 8'h05);
    wait_cyc(6);
    `CHK(cpu_src, clk_seq_pkg::SRC_SUB)
    wr(clk_seq_pkg::OFF_PROC_CLK, 8'h01);
    do_switch(2, 1, clk_seq_pkg::SRC_HIGH, clk_seq_pkg::CS_HIGH_RUN);
  endtask
  task automatic main_osc_options();
    wr(clk_seq_pkg::OFF_INT_OSC, 8'h01);
    wait_cyc(1);
    `CHK(osc_en.int_hs, 1'b0)
    chk_rd(clk_seq_pkg::OFF_INT_OSC, 32'h0000_0001);
    wr(clk_seq_pkg::OFF_OSC_MODE, 8'hD0);
    @(posedge pclk);
    x1_tick <= 1'b1;
    @(posedge pclk);
    x1_tick <= 1'b0;
    wait_cyc(1);
    `CHK(osc_en.ext, 1'b1)
    `CHK(osc_en.x1, 1'b0)
    chk_rd(clk_seq_pkg::OFF_STAB_CNT, 32'h0000_0000);
    wr(clk_seq_pkg::OFF_MAIN_OSC, 8'h80);
    wait_cyc(1);
    `CHK(osc_en.ext, 1'b0)
  endtask

  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    thr_opt = 1'b1;
    sup_low = 1'b1;
    sup_high = 1'b0;
    halt_exec = 1'b0;
    halt_release = 1'b0;
    int_osc_stable = 1'b1;
    x1_tick = 1'b0;
    src_safe_edge = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    poc_and_reset();
    once_only_bits();
    to_high_speed();
    do_halt(clk_seq_pkg::CS_HIGH_HALT, clk_seq_pkg::CS_HIGH_RUN);
    back_to_internal();
    do_halt(clk_seq_pkg::CS_INT_HALT, clk_seq_pkg::CS_INT_RUN);
    sub_round_trip();
    main_osc_options();
    test_done();
  end
endmodule
`default_nettype wire
